// ==== dv/tb_tcm_timer.sv ====
`timescale 1ns/1ps
`include "tcm_map.vh"
module tb_tcm_timer;
  logic        ref_clk     = 1'b0;
  logic        reset       = 1'b1;
  logic        standby     = 1'b0;
  logic [7:0]  paddr       = 8'h00;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [31:0] pwdata      = 32'h0;
  logic [3:0]  pin         = 4'h0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [6:0]  irq;
  logic [31:0] rd;
  logic [31:0] v;
  logic        err;
  int          errors      = 0;
  int          checks_done = 0;
  always #20 ref_clk = ~ref_clk;
  tcm_timer i_tcm_timer (.ref_clk(ref_clk), .reset(reset), .standby(standby), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_a_pin(pin[0]), .capture_b_pin(pin[1]), .capture_c_pin(pin[2]), .capture_d_pin(pin[3]),
    .capture_a_irq(irq[6]), .capture_b_irq(irq[5]), .capture_c_irq(irq[4]), .capture_d_irq(irq[3]),
    .compare_a_irq(irq[2]), .compare_b_irq(irq[1]), .overflow_irq(irq[0]));
  // ************
  // tasks
  // ************
  task automatic close_out;
    $display("checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      errors++;
      close_out();
    end
  endtask
  task automatic clr_all;
    apb(`TCM_OFS_CSR, 1'b0, 32'h0);
    apb(`TCM_OFS_CSR, 1'b1, {31'h0, rd[0]});
  endtask
  // rising edge on one pin, held well past the synchroniser
  task automatic edge_on(input int ch);
    @(posedge ref_clk);
    pin[ch] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    pin[ch] <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
  // ************
  // sequence
  // ************
  initial begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    apb(`TCM_OFS_IER, 1'b0, 32'h0); check(rd, 32'h01);
    apb(`TCM_OFS_CSR, 1'b0, 32'h0); check(rd, 32'h00);
    apb(`TCM_OFS_MASKW, 1'b0, 32'h0); check(rd, 32'h00);
    apb(8'h30, 1'b0, 32'h0); check({rd[30:0], err}, 32'h1);
    apb(`TCM_OFS_IER, 1'b1, 32'h0); apb(`TCM_OFS_IER, 1'b0, 32'h0); check(rd, 32'h01);
    apb(`TCM_OFS_MASKW, 1'b1, 32'hffffffff); apb(`TCM_OFS_MASKW, 1'b0, 32'h0); check(rd, 32'hff);
    apb(`TCM_OFS_IER, 1'b1, 32'hfe);
    apb(`TCM_OFS_CSR, 1'b1, 32'h1); apb(`TCM_OFS_CSR, 1'b0, 32'h0); check(rd, 32'h01);
    @(posedge ref_clk);
    standby <= 1'b1;
    repeat (2) @(posedge ref_clk);
    standby <= 1'b0;
    apb(`TCM_OFS_CSR, 1'b0, 32'h0); check(rd, 32'h00);
    apb(`TCM_OFS_IER, 1'b0, 32'h0); check(rd, 32'h01);
    apb(`TCM_OFS_MASKW, 1'b0, 32'h0); check(rd, 32'h00);
    apb(`TCM_OFS_TCTL, 1'b1, 32'hf0);
    apb(`TCM_OFS_IER, 1'b1, 32'hfe);
    for (int k = 0; k < 3; k++) edge_on(k);
    apb(`TCM_OFS_CSR, 1'b0, 32'h0); check(rd & 32'he0, 32'he0);
    check(32'(irq[6:4]), 32'h7);
    clr_all(); check(rd & 32'he0, 32'he0);
    apb(`TCM_OFS_CSR, 1'b0, 32'h0); check(rd, 32'h00);
    edge_on(0);
    apb(`TCM_OFS_CSR, 1'b1, 32'h0); apb(`TCM_OFS_CSR, 1'b0, 32'h0); check(rd, 32'h80);
    apb(`TCM_OFS_CSR, 1'b1, 32'hfe); apb(`TCM_OFS_CSR, 1'b0, 32'h0); check(rd, 32'h80);
    apb(`TCM_OFS_IER, 1'b1, 32'h7e);
    repeat (3) @(posedge ref_clk);
    check(32'(irq[6]), 32'h0);
    clr_all();
    apb(`TCM_OFS_TCTL, 1'b1, 32'hfc);
    for (int k = 0; k < 2; k++) begin
      edge_on(k); apb(8'(`TCM_OFS_CAPA + 4 * k), 1'b0, 32'h0); v = rd;
      edge_on(k); apb(8'(`TCM_OFS_CAPC + 4 * k), 1'b0, 32'h0); check(rd, v);
      clr_all(); edge_on(k + 2);
      apb(8'(`TCM_OFS_CAPC + 4 * k), 1'b0, 32'h0); check(rd, v);
      apb(`TCM_OFS_CSR, 1'b0, 32'h0); check(rd, 32'h20 >> k);
    end
    apb(`TCM_OFS_TCTL, 1'b1, 32'hf0);
    apb(`TCM_OFS_CCTL, 1'b1, 32'h1);
    for (int w = 1; w >= 0; w--) begin
      apb(`TCM_OFS_MASKW, 1'b1, 32'(w * 8'h40));
      clr_all(); edge_on(3); apb(`TCM_OFS_CAPD, 1'b0, 32'h0); v = rd;
      clr_all(); edge_on(3);
      apb(`TCM_OFS_CSR, 1'b0, 32'h0); check(rd & 32'h10, w ? 32'h0 : 32'h10);
      apb(`TCM_OFS_CAPD, 1'b0, 32'h0); check(32'(rd === v), 32'(w));
      repeat (150) @(posedge ref_clk);
      clr_all(); edge_on(3);
      apb(`TCM_OFS_CSR, 1'b0, 32'h0); check(rd & 32'h10, 32'h10);
      // let the interval started by the last edge run out
      repeat (150) @(posedge ref_clk);
    end
    apb(`TCM_OFS_IER, 1'b1, 32'hfe);
    clr_all();
    apb(`TCM_OFS_CMPB, 1'b1, 32'h0100); apb(`TCM_OFS_CNT, 1'b1, 32'h00f0);
    repeat (40) @(posedge ref_clk);
    apb(`TCM_OFS_CSR, 1'b0, 32'h0); check(rd & 32'h0e, 32'h04);
    apb(`TCM_OFS_CNT, 1'b1, 32'hfff0);
    repeat (40) @(posedge ref_clk);
    apb(`TCM_OFS_CSR, 1'b0, 32'h0); check(rd & 32'h0e, 32'h0e);
    check(32'(irq[2:0]), 32'h7);
    apb(`TCM_OFS_IER, 1'b1, 32'h0);
    repeat (3) @(posedge ref_clk);
    check(32'(irq), 32'h0);
    apb(`TCM_OFS_CMPA, 1'b1, 32'h5); apb(`TCM_OFS_CSR, 1'b1, 32'h1); apb(`TCM_OFS_CNT, 1'b1, 32'h0);
    repeat (20) @(posedge ref_clk);
    apb(`TCM_OFS_CNT, 1'b0, 32'h0); check(32'(rd <= 32'h5), 32'h1);
    apb(`TCM_OFS_CSR, 1'b1, 32'h0);
    repeat (20) @(posedge ref_clk);
    apb(`TCM_OFS_CNT, 1'b0, 32'h0); check(32'(rd > 32'h5), 32'h1);
    close_out();
  end
endmodule // tb_tcm_timer
bind tcm_timer tcm_timer_monitor #(.AW(AW)) i_tcm_timer_monitor (.ref_clk(ref_clk), .reset(reset),
  .standby(standby), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_a_irq(capture_a_irq),
  .capture_b_irq(capture_b_irq), .capture_c_irq(capture_c_irq), .capture_d_irq(capture_d_irq),
  .compare_a_irq(compare_a_irq), .compare_b_irq(compare_b_irq), .overflow_irq(overflow_irq));

// ==== dv/tcm_timer_monitor.sv ====
`timescale 1ns/1ps
`include "tcm_map.vh"
module tcm_timer_monitor #(
  parameter AW = 8
) (
  input logic          ref_clk,
  input logic          reset,
  input logic          standby,
  input logic [AW-1:0] paddr,
  input logic          psel,
  input logic          penable,
  input logic          pwrite,
  input logic [31:0]   pwdata,
  input logic [31:0]   prdata,
  input logic          pready,
  input logic          pslverr,
  input logic          capture_a_irq,
  input logic          capture_b_irq,
  input logic          capture_c_irq,
  input logic          capture_d_irq,
  input logic          compare_a_irq,
  input logic          compare_b_irq,
  input logic          overflow_irq
);
  // ************
  // bus and interrupt checks
  // ************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire acc    = psel && penable && pready;
  wire ier_wr = acc && pwrite && (paddr == `TCM_OFS_IER);
  wire clr_wr = ier_wr || (acc && pwrite && (paddr == `TCM_OFS_CSR));
  // a request drops only through a software write or standby
  property irq_holds(q);
    q && !clr_wr && !$past(clr_wr) && !standby && !$past(standby) |=> q;
  endproperty
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_timing: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("ready not in second access cycle");
  a_unmapped_err: assert property (acc && paddr > `TCM_OFS_MASKW |-> pslverr)
    else $error("unmapped access without error");
  a_mask_upper_zero: assert property (acc && !pwrite && paddr == `TCM_OFS_MASKW |-> prdata[31:8] == 24'h0)
    else $error("mask width upper bits not zero");
  a_fixed_bit_one: assert property (acc && !pwrite && paddr == `TCM_OFS_IER |-> prdata[0])
    else $error("enable bit 0 not one");
  a_reset_quiet: assert property ($past(reset) |-> !(capture_a_irq || capture_b_irq || capture_c_irq
    || capture_d_irq || compare_a_irq || compare_b_irq || overflow_irq) && !pready)
    else $error("request after reset");
  a_capa_gated: assert property (ier_wr && !pwdata[7] |-> ##2 !capture_a_irq)
    else $error("capture a request while disabled");
  a_capd_gated: assert property (ier_wr && !pwdata[4] |-> ##2 !capture_d_irq)
    else $error("capture d request while disabled");
  a_cmpa_gated: assert property (ier_wr && !pwdata[3] |-> ##2 !compare_a_irq)
    else $error("compare a request while disabled");
  a_ovf_gated: assert property (ier_wr && !pwdata[1] |-> ##2 !overflow_irq)
    else $error("overflow request while disabled");
  a_capa_holds: assert property (irq_holds(capture_a_irq))
    else $error("capture a request dropped");
  a_ovf_holds: assert property (irq_holds(overflow_irq))
    else $error("overflow request dropped");
  cover property (acc && pslverr);
  cover property (capture_d_irq);
  cover property (overflow_irq);
endmodule // tcm_timer_monitor

// ==== rtl/tcm_map.vh ====
//Contract
// - mask width register: upper 24 bits (31 to 8) read zero, ignore writes; lower eight read/write.
// - mask enabled and width nonzero: accepted channel D capture starts a mask interval.
// - mask interval ends when counter equals capture D plus twice the mask width.
// - during a mask interval channel D edges neither load capture D nor set its flag.
// - mask enabled with zero width never masks; channel D captures proceed normally.
// - mask width clears to zero on reset and on standby entry.
// - interrupt enable resets to 0x01; bit 0 always reads one, ignores writes.
// - enable bits 7 to 4 gate capture interrupts A to D; one enables.
// - enable bits 3 and 2 gate compare A and B interrupts; one enables.
// - enable bit 1 gates the overflow interrupt; one enables.
// - status bits 7 to 1 set only by hardware; software writes zero to clear.
// - a flag clears only after it was read as one, then written zero; one set as the read data is taken is armed though read as zero.
// - capture on A or B copies counter into its register and sets its flag.
// - buffered A capture moves old capture A into capture C, loads A, sets flag.
// - buffered B capture moves old capture B into capture D, loads B, sets flag.
// - unbuffered channel C capture loads capture C and sets its flag.
// - buffered A mode: pin C edge sets flag C without loading capture C.
// - control/status resets to zero on reset and on standby entry.
// - clear-on-match A set clears counter on compare A match; else it runs.
// - overflow flag sets when counter wraps from maximum to zero.
// - buffered B mode: pin D edge sets flag D without loading capture D.
`ifndef TCM_MAP_VH
`define TCM_MAP_VH
// ************
// register offsets
// ************
`define TCM_OFS_IER    8'h00
`define TCM_OFS_CSR    8'h04
`define TCM_OFS_CNT    8'h08
`define TCM_OFS_CMPA   8'h0c
`define TCM_OFS_CMPB   8'h10
`define TCM_OFS_TCTL   8'h14
`define TCM_OFS_CCTL   8'h18
`define TCM_OFS_CAPA   8'h1c
`define TCM_OFS_CAPB   8'h20
`define TCM_OFS_CAPC   8'h24
`define TCM_OFS_CAPD   8'h28
`define TCM_OFS_MASKW  8'h2c
// ************
// reset values
// ************
`define TCM_RST_IER    8'h01
`define TCM_RST_CSR    8'h00
`define TCM_RST_CNT    16'h0000
`define TCM_RST_CMP    16'hffff
`define TCM_RST_CAP    16'h0000
`define TCM_RST_BYTE   8'h00
`define TCM_RST_MASKW  8'h00
`define TCM_IER_FIXED  8'h01
`define TCM_FLAG_MASK  8'hfe
`define TCM_CNT_MAX    16'hffff
`define TCM_CNT_ONE    16'h0001
// ************
// field positions
// ************
`define TCM_B_FA       7
`define TCM_B_FB       6
`define TCM_B_FC       5
`define TCM_B_FD       4
`define TCM_B_CMA      3
`define TCM_B_CMB      2
`define TCM_B_OVF      1
`define TCM_B_CLRA     0
`define TCM_B_SELA     7
`define TCM_B_SELB     6
`define TCM_B_SELC     5
`define TCM_B_SELD     4
`define TCM_B_BUFA     3
`define TCM_B_BUFB     2
`define TCM_B_MASKEN   0
`endif

// ==== rtl/tcm_timer.v ====
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "tcm_map.vh"
module tcm_timer #(
  parameter AW = 8,
  parameter CW = 16
) (
  input  wire          ref_clk,
  input  wire          reset,
  input  wire          standby,
  input  wire [AW-1:0] paddr,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  input  wire          capture_a_pin,
  input  wire          capture_b_pin,
  input  wire          capture_c_pin,
  input  wire          capture_d_pin,
  output reg           capture_a_irq,
  output reg           capture_b_irq,
  output reg           capture_c_irq,
  output reg           capture_d_irq,
  output reg           compare_a_irq,
  output reg           compare_b_irq,
  output reg           overflow_irq
);

  // ************
  // storage
  // ************
  reg  [7:0]    interrupt_enable_r;
  reg  [7:0]    control_status_r;
  reg  [7:0]    read_armed_r;
  reg  [CW-1:0] free_counter_r;
  reg  [CW-1:0] compare_reg_a_r;
  reg  [CW-1:0] compare_reg_b_r;
  reg  [7:0]    timer_control_r;
  reg  [7:0]    compare_control_r;
  reg  [CW-1:0] capture_reg_a_r;
  reg  [CW-1:0] capture_reg_b_r;
  reg  [CW-1:0] capture_reg_c_r;
  reg  [CW-1:0] capture_reg_d_r;
  reg  [7:0]    capture_d_mask_width_r;
  reg           mask_active_r;
  reg  [3:0]    sync1_r;
  reg  [3:0]    sync2_r;
  reg  [3:0]    sync3_r;
  reg  [3:0]    pin_level_r;

  wire          clr = reset | standby;

  // ************
  // pin edge detection
  // ************
  wire [3:0] pins = {capture_d_pin, capture_c_pin, capture_b_pin, capture_a_pin};
  wire [3:0] pin_chg = ~(sync2_r ^ sync3_r) & (sync3_r ^ pin_level_r);
  wire [3:0] pin_rise = pin_chg & sync3_r;

  always @(posedge ref_clk) begin
    if (clr) begin
      sync1_r     <= 4'h0;
      sync2_r     <= 4'h0;
      sync3_r     <= 4'h0;
      pin_level_r <= 4'h0;
    end else begin
      sync1_r     <= pins;
      sync2_r     <= sync1_r;
      sync3_r     <= sync2_r;
      pin_level_r <= pin_level_r ^ pin_chg;
    end
  end

  // edge matches select bit: one is rising, zero is falling
  function edge_hit;
    input chg;
    input rise;
    input sel;
    begin
      edge_hit = chg & (rise == sel);
    end
  endfunction

  wire sel_a  = timer_control_r[`TCM_B_SELA];
  wire sel_b  = timer_control_r[`TCM_B_SELB];
  wire sel_c  = timer_control_r[`TCM_B_SELC];
  wire sel_d  = timer_control_r[`TCM_B_SELD];
  wire buf_a  = timer_control_r[`TCM_B_BUFA];
  wire buf_b  = timer_control_r[`TCM_B_BUFB];
  wire mask_en = compare_control_r[`TCM_B_MASKEN];

  // buffered mode: a second select lets both edges capture
  wire cap_a = edge_hit(pin_chg[0], pin_rise[0], sel_a) |
               (buf_a & edge_hit(pin_chg[0], pin_rise[0], sel_c));
  wire cap_b = edge_hit(pin_chg[1], pin_rise[1], sel_b) |
               (buf_b & edge_hit(pin_chg[1], pin_rise[1], sel_d));
  wire evt_c = edge_hit(pin_chg[2], pin_rise[2], sel_c);
  wire evt_d = edge_hit(pin_chg[3], pin_rise[3], sel_d) & ~mask_active_r;
  wire load_c = evt_c & ~buf_a;
  wire load_d = evt_d & ~buf_b;

  // ************
  // counter and compare
  // ************
  wire match_a = (free_counter_r == compare_reg_a_r);
  wire match_b = (free_counter_r == compare_reg_b_r);
  wire clr_on_a = control_status_r[`TCM_B_CLRA] & match_a;
  wire wrap = (free_counter_r == `TCM_CNT_MAX) & ~clr_on_a;
  wire [CW-1:0] mask_end = capture_reg_d_r + {{(CW-9){1'b0}}, capture_d_mask_width_r, 1'b0};

  // ************
  // bus slave
  // ************
  wire acc = psel & penable & pready;
  wire wr  = acc & pwrite;
  wire rd  = acc & ~pwrite;

  function is_reg;
    input [AW-1:0] a;
    input [7:0] ofs;
    begin
      is_reg = (a == ofs[AW-1:0]);
    end
  endfunction

  wire w_ier  = wr & is_reg(paddr, `TCM_OFS_IER);
  wire w_csr  = wr & is_reg(paddr, `TCM_OFS_CSR);
  wire r_csr  = rd & is_reg(paddr, `TCM_OFS_CSR);
  wire w_cnt  = wr & is_reg(paddr, `TCM_OFS_CNT);
  wire w_cmpa = wr & is_reg(paddr, `TCM_OFS_CMPA);
  wire w_cmpb = wr & is_reg(paddr, `TCM_OFS_CMPB);
  wire w_tctl = wr & is_reg(paddr, `TCM_OFS_TCTL);
  wire w_cctl = wr & is_reg(paddr, `TCM_OFS_CCTL);
  wire w_mskw = wr & is_reg(paddr, `TCM_OFS_MASKW);

  reg [31:0] rdata_nxt;
  reg        hit_nxt;
  always @* begin
    rdata_nxt = 32'h0000_0000;
    hit_nxt   = 1'b1;
    case (paddr)
      `TCM_OFS_IER:   rdata_nxt[7:0] = interrupt_enable_r;
      `TCM_OFS_CSR:   rdata_nxt[7:0] = control_status_r;
      `TCM_OFS_CNT:   rdata_nxt[CW-1:0] = free_counter_r;
      `TCM_OFS_CMPA:  rdata_nxt[CW-1:0] = compare_reg_a_r;
      `TCM_OFS_CMPB:  rdata_nxt[CW-1:0] = compare_reg_b_r;
      `TCM_OFS_TCTL:  rdata_nxt[7:0] = timer_control_r;
      `TCM_OFS_CCTL:  rdata_nxt[7:0] = compare_control_r;
      `TCM_OFS_CAPA:  rdata_nxt[CW-1:0] = capture_reg_a_r;
      `TCM_OFS_CAPB:  rdata_nxt[CW-1:0] = capture_reg_b_r;
      `TCM_OFS_CAPC:  rdata_nxt[CW-1:0] = capture_reg_c_r;
      `TCM_OFS_CAPD:  rdata_nxt[CW-1:0] = capture_reg_d_r;
      `TCM_OFS_MASKW: rdata_nxt[7:0] = capture_d_mask_width_r;
      default:        hit_nxt = 1'b0;
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always @(posedge ref_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit_nxt;
      if (psel & penable & ~pready & ~pwrite)
        prdata <= rdata_nxt;
    end
  end

  // ************
  // status flags
  // ************
  wire [7:0] flag_set;
  assign flag_set[`TCM_B_FA]   = cap_a;
  assign flag_set[`TCM_B_FB]   = cap_b;
  assign flag_set[`TCM_B_FC]   = evt_c;
  assign flag_set[`TCM_B_FD]   = evt_d;
  assign flag_set[`TCM_B_CMA]  = match_a;
  assign flag_set[`TCM_B_CMB]  = match_b;
  assign flag_set[`TCM_B_OVF]  = wrap;
  assign flag_set[`TCM_B_CLRA] = 1'b0;

  // write zero clears only an armed flag; a one has no effect
  wire [7:0] flag_clr = w_csr ? (~pwdata[7:0] & read_armed_r & `TCM_FLAG_MASK) : 8'h00;
  wire [7:0] csr_nxt  = ((control_status_r & ~flag_clr) | flag_set) & `TCM_FLAG_MASK;

  always @(posedge ref_clk) begin
    if (clr) begin
      control_status_r <= `TCM_RST_CSR;
      read_armed_r     <= `TCM_RST_CSR;
    end else begin
      control_status_r <= csr_nxt | (w_csr ? (pwdata[7:0] & `TCM_IER_FIXED) :
                                             (control_status_r & `TCM_IER_FIXED));
      if (r_csr)
        read_armed_r <= control_status_r & `TCM_FLAG_MASK;
      else if (w_csr)
        read_armed_r <= `TCM_RST_CSR;
    end
  end

  // ************
  // control registers
  // ************
  always @(posedge ref_clk) begin
    if (clr) begin
      interrupt_enable_r     <= `TCM_RST_IER;
      compare_reg_a_r        <= `TCM_RST_CMP;
      compare_reg_b_r        <= `TCM_RST_CMP;
      timer_control_r        <= `TCM_RST_BYTE;
      compare_control_r      <= `TCM_RST_BYTE;
      capture_d_mask_width_r <= `TCM_RST_MASKW;
    end else begin
      if (w_ier)
        interrupt_enable_r <= pwdata[7:0] | `TCM_IER_FIXED;
      if (w_cmpa)
        compare_reg_a_r <= pwdata[CW-1:0];
      if (w_cmpb)
        compare_reg_b_r <= pwdata[CW-1:0];
      if (w_tctl)
        timer_control_r <= pwdata[7:0];
      if (w_cctl)
        compare_control_r <= pwdata[7:0] & `TCM_IER_FIXED;
      if (w_mskw)
        capture_d_mask_width_r <= pwdata[7:0];
    end
  end

  // ************
  // counter
  // ************
  always @(posedge ref_clk) begin
    if (clr)
      free_counter_r <= `TCM_RST_CNT;
    else if (w_cnt)
      free_counter_r <= pwdata[CW-1:0];
    else if (clr_on_a)
      free_counter_r <= `TCM_RST_CNT;
    else
      free_counter_r <= free_counter_r + `TCM_CNT_ONE;
  end

  // ************
  // capture registers
  // ************
  always @(posedge ref_clk) begin
    if (clr) begin
      capture_reg_a_r <= `TCM_RST_CAP;
      capture_reg_b_r <= `TCM_RST_CAP;
      capture_reg_c_r <= `TCM_RST_CAP;
      capture_reg_d_r <= `TCM_RST_CAP;
    end else begin
      if (cap_a)
        capture_reg_a_r <= free_counter_r;
      if (cap_b)
        capture_reg_b_r <= free_counter_r;
      if (buf_a & cap_a)
        capture_reg_c_r <= capture_reg_a_r;
      else if (load_c)
        capture_reg_c_r <= free_counter_r;
      if (buf_b & cap_b)
        capture_reg_d_r <= capture_reg_b_r;
      else if (load_d)
        capture_reg_d_r <= free_counter_r;
    end
  end

  // ************
  // channel d mask interval
  // ************
  always @(posedge ref_clk) begin
    if (clr)
      mask_active_r <= 1'b0;
    else if (load_d)
      mask_active_r <= mask_en & (capture_d_mask_width_r != `TCM_RST_MASKW);
    else if (mask_active_r & (free_counter_r == mask_end))
      mask_active_r <= 1'b0;
  end

  // ************
  // interrupt requests
  // ************
  always @(posedge ref_clk) begin
    if (clr) begin
      capture_a_irq <= 1'b0;
      capture_b_irq <= 1'b0;
      capture_c_irq <= 1'b0;
      capture_d_irq <= 1'b0;
      compare_a_irq <= 1'b0;
      compare_b_irq <= 1'b0;
      overflow_irq  <= 1'b0;
    end else begin
      capture_a_irq <= csr_nxt[`TCM_B_FA] & interrupt_enable_r[`TCM_B_FA];
      capture_b_irq <= csr_nxt[`TCM_B_FB] & interrupt_enable_r[`TCM_B_FB];
      capture_c_irq <= csr_nxt[`TCM_B_FC] & interrupt_enable_r[`TCM_B_FC];
      capture_d_irq <= csr_nxt[`TCM_B_FD] & interrupt_enable_r[`TCM_B_FD];
      compare_a_irq <= csr_nxt[`TCM_B_CMA] & interrupt_enable_r[`TCM_B_CMA];
      compare_b_irq <= csr_nxt[`TCM_B_CMB] & interrupt_enable_r[`TCM_B_CMB];
      overflow_irq  <= csr_nxt[`TCM_B_OVF] & interrupt_enable_r[`TCM_B_OVF];
    end
  end

endmodule // tcm_timer
